// ==== src/gpcg_regs.vh ====
// constants for the port clock gating block: offsets, field positions, reset values
// assumes a 32-bit axi4-lite register window with byte addresses
`ifndef GPCG_REGS_VH
`define GPCG_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define GPCG_RUN_CLOCK_CONFIG_OFF   12'h060 // run_clock_config, holds auto gating select
`define GPCG_RUN_PORT_GATE_OFF      12'h108 // run_port_clock_gating
`define GPCG_SLEEP_PORT_GATE_OFF    12'h118 // sleep_port_clock_gating
`define GPCG_DEEP_PORT_GATE_OFF     12'h128 // deep_sleep_port_clock_gating
`define GPCG_POWER_MODE_OFF         12'h130 // power mode request and status

// ****************************************************************
// field positions and widths
// ****************************************************************
`define GPCG_PORT_MSB               7       // port h enable bit
`define GPCG_PORT_LSB               0       // port a enable bit
`define GPCG_AUTO_GATE_BIT          27      // auto_sleep_gating_select in run_clock_config
`define GPCG_MODE_MSB               1       // power mode field, bits 1:0
`define GPCG_ACTIVE_MSB             15      // active enables readback in mode register
`define GPCG_ACTIVE_LSB             8

// ****************************************************************
// reset values and encodings
// ****************************************************************
`define GPCG_PORT_RESET             8'h00
`define GPCG_MODE_RUN               2'h0
`define GPCG_MODE_SLEEP             2'h1
`define GPCG_MODE_DEEP              2'h2

// ****************************************************************
// axi response codes
// ****************************************************************
`define GPCG_RESP_OKAY              2'h0
`define GPCG_RESP_SLVERR            2'h2

`endif

// ==== src/gpcg_port_gate.v ====
// per-port clock enable selection and access fault check
// assumes enable vectors are registered in the caller's clock domain
`timescale 1ns/1ps
`include "gpcg_regs.vh"

module gpcg_port_gate #(
    parameter N_PORTS = 8
) (
    input  wire [N_PORTS-1:0] run_en,
    input  wire [N_PORTS-1:0] sleep_en,
    input  wire [N_PORTS-1:0] deep_en,
    input  wire               auto_gate,
    input  wire [1:0]         power_mode,
    input  wire [N_PORTS-1:0] port_access,
    output wire [N_PORTS-1:0] port_clk_en,
    output wire [N_PORTS-1:0] port_fault
);

    // ****************************************************************
    // per-port selection
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < N_PORTS; i = i + 1) begin : g_port
            wire sel_sleep; // sleep table in force for this port
            wire sel_deep;  // deep table in force for this port
            assign sel_sleep = auto_gate && (power_mode == `GPCG_MODE_SLEEP);
            assign sel_deep  = auto_gate && (power_mode == `GPCG_MODE_DEEP);
            // run table keeps control when auto gating is off
            assign port_clk_en[i] = sel_sleep ? sleep_en[i] :
                                    sel_deep  ? deep_en[i]  : run_en[i];
            // access to an unclocked port faults
            assign port_fault[i] = port_access[i] & ~port_clk_en[i];
        end
    endgenerate

endmodule

// ==== src/gpcg_top.v ====
// axi4-lite register block gating the clocks of eight i/o ports
// assumes a single 100 mhz clock; port modules use port_clk_en as enable
`timescale 1ns/1ps
`include "gpcg_regs.vh"

// Summary of operation
// - bits 7..0 enable ports h..a
// - set bit clocks port, clear disables
// - access to unclocked port gives fault
// - all enable bits reset to zero
// - bits 31..8 read zero, ignore writes
// - 0x118 sleep enables, 0x128 deep enables
// - sleep tables only with auto gating set
// - run register 0x108 governs running operation
module gpcg_top #(
    parameter N_PORTS = 8
) (
    input  wire               clk,
    input  wire               rst_n,
    input  wire [11:0]        s_axi_awaddr,
    input  wire               s_axi_awvalid,
    output wire               s_axi_awready,
    input  wire [31:0]        s_axi_wdata,
    input  wire [3:0]         s_axi_wstrb,
    input  wire               s_axi_wvalid,
    output wire               s_axi_wready,
    output reg  [1:0]         s_axi_bresp,
    output reg                s_axi_bvalid,
    input  wire               s_axi_bready,
    input  wire [11:0]        s_axi_araddr,
    input  wire               s_axi_arvalid,
    output wire               s_axi_arready,
    output reg  [31:0]        s_axi_rdata,
    output reg  [1:0]         s_axi_rresp,
    output reg                s_axi_rvalid,
    input  wire               s_axi_rready,
    input  wire [N_PORTS-1:0] port_access,
    output wire [N_PORTS-1:0] port_clk_en,
    output wire [N_PORTS-1:0] port_fault
);

    // ****************************************************************
    // state
    // ****************************************************************
    reg  [N_PORTS-1:0] run_gate_q;    // run_port_clock_gating
    reg  [N_PORTS-1:0] sleep_gate_q;  // sleep_port_clock_gating
    reg  [N_PORTS-1:0] deep_gate_q;   // deep_sleep_port_clock_gating
    reg                auto_gate_q;   // auto_sleep_gating_select
    reg  [1:0]         mode_q;        // requested power mode
    reg  [11:0]        aw_addr_q;     // latched write address
    reg                aw_have_q;     // write address held
    reg  [31:0]        w_data_q;      // latched write data
    reg  [3:0]         w_strb_q;      // latched strobes
    reg                w_have_q;      // write data held
    wire               wr_go;         // both halves present, response slot free
    wire               wr_hit;        // write address mapped
    reg  [31:0]        rd_val;        // read mux value
    reg                rd_hit;        // read address mapped

    // ****************************************************************
    // write channel acceptance
    // ****************************************************************
    // address and data may come in either order; each is held until paired
    assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
    assign wr_go         = aw_have_q & w_have_q;
    assign wr_hit        = (aw_addr_q == `GPCG_RUN_CLOCK_CONFIG_OFF) ||
                           (aw_addr_q == `GPCG_RUN_PORT_GATE_OFF)    ||
                           (aw_addr_q == `GPCG_SLEEP_PORT_GATE_OFF)  ||
                           (aw_addr_q == `GPCG_DEEP_PORT_GATE_OFF)   ||
                           (aw_addr_q == `GPCG_POWER_MODE_OFF);

    // capture address and data halves
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_addr_q <= 12'h000;
            aw_have_q <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            w_have_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
                aw_have_q <= 1'b1;
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // register writes and write response
    // ****************************************************************
    // only byte lane 0 carries enables; upper lanes of the gating registers are read-only zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_gate_q   <= `GPCG_PORT_RESET;
            sleep_gate_q <= `GPCG_PORT_RESET;
            deep_gate_q  <= `GPCG_PORT_RESET;
            auto_gate_q  <= 1'b0;
            mode_q       <= `GPCG_MODE_RUN;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `GPCG_RESP_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `GPCG_RESP_OKAY : `GPCG_RESP_SLVERR;
                if (w_strb_q[0]) begin
                    case (aw_addr_q)
                        `GPCG_RUN_PORT_GATE_OFF:   run_gate_q   <= w_data_q[7:0];
                        `GPCG_SLEEP_PORT_GATE_OFF: sleep_gate_q <= w_data_q[7:0];
                        `GPCG_DEEP_PORT_GATE_OFF:  deep_gate_q  <= w_data_q[7:0];
                        `GPCG_POWER_MODE_OFF:      mode_q       <= w_data_q[1:0];
                        default: begin
                        end
                    endcase
                end
                // auto gating select lives in byte lane 3
                if (w_strb_q[3] && aw_addr_q == `GPCG_RUN_CLOCK_CONFIG_OFF) begin
                    auto_gate_q <= w_data_q[`GPCG_AUTO_GATE_BIT];
                end
            end
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    // combinational decode; upper bits of the gating registers stay zero
    always @* begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case ({s_axi_araddr[11:2], 2'b00})
            `GPCG_RUN_CLOCK_CONFIG_OFF: rd_val[`GPCG_AUTO_GATE_BIT] = auto_gate_q;
            `GPCG_RUN_PORT_GATE_OFF:    rd_val[7:0] = run_gate_q;
            `GPCG_SLEEP_PORT_GATE_OFF:  rd_val[7:0] = sleep_gate_q;
            `GPCG_DEEP_PORT_GATE_OFF:   rd_val[7:0] = deep_gate_q;
            `GPCG_POWER_MODE_OFF: begin
                // live enables let software see which ports run now
                rd_val[1:0]  = mode_q;
                rd_val[15:8] = port_clk_en;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = ~s_axi_rvalid;

    // read data register, one cycle after acceptance
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `GPCG_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_hit ? `GPCG_RESP_OKAY : `GPCG_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // port enable selection
    // ****************************************************************
    // enables drive port clock gates; a zero stops that port entirely
    gpcg_port_gate #(
        .N_PORTS (N_PORTS)
    ) u_gate (
        .run_en      (run_gate_q),
        .sleep_en    (sleep_gate_q),
        .deep_en     (deep_gate_q),
        .auto_gate   (auto_gate_q),
        .power_mode  (mode_q),
        .port_access (port_access),
        .port_clk_en (port_clk_en),
        .port_fault  (port_fault)
    );

endmodule

// ==== dv/gpcg_properties.sv ====
// checker for the port clock gating block: bus timing, enables and faults
// assumes it is bound to gpcg_top and sees only that module's ports
`timescale 1ns/1ps
module gpcg_properties #(
    parameter N_PORTS = 8
) (
    input wire               clk,
    input wire               rst_n,
    input wire               s_axi_awvalid,
    input wire               s_axi_awready,
    input wire               s_axi_wvalid,
    input wire               s_axi_wready,
    input wire [1:0]         s_axi_bresp,
    input wire               s_axi_bvalid,
    input wire               s_axi_bready,
    input wire               s_axi_arvalid,
    input wire               s_axi_arready,
    input wire [31:0]        s_axi_rdata,
    input wire [1:0]         s_axi_rresp,
    input wire               s_axi_rvalid,
    input wire               s_axi_rready,
    input wire [N_PORTS-1:0] port_access,
    input wire [N_PORTS-1:0] port_clk_en,
    input wire [N_PORTS-1:0] port_fault
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_fault_rule: assert property (port_fault == (port_access & ~port_clk_en))
        else $error("fault output differs from access and enable");
    a_reset_clear: assert property ($rose(rst_n) |-> port_clk_en == {N_PORTS{1'b0}})
        else $error("port enable not clear after reset");
    a_enable_on_write: assert property ($changed(port_clk_en) |-> $rose(s_axi_bvalid))
        else $error("port enable moved without a write");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_turn: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    a_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule

// ==== dv/gpcg_port_model.sv ====
// model of the eight gated port modules on the far side
// assumes the bench says which ports software touches each cycle
`timescale 1ns/1ps
module gpcg_port_model (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] want,
    output reg  [7:0] port_access
);
    // each port bus cycle is one clock; nothing is touched during reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_access <= 8'h00;
        end else begin
            port_access <= want;
        end
    end
endmodule

// ==== dv/gpcg_top_tb.sv ====
// self-checking bench for the port clock gating block
// assumes the design under src and the checker and port model under dv
`timescale 1ns/1ps
`include "gpcg_regs.vh"
module gpcg_top_tb;
    reg         clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    reg         bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
    reg  [31:0] wdata = 32'h00000000, rnd = 32'h0000004a, d;
    reg  [31:0] v [0:2];    // shadow of run, sleep and deep registers
    reg  [7:0]  want = 8'h00;
    reg  [1:0]  r;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [7:0]  acc, en, flt;
    integer     miscompares = 0, checks_done = 0, cyc = 0, i, k;

    gpcg_top #(.N_PORTS(8)) gpcg_top_i (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port_access(acc), .port_clk_en(en), .port_fault(flt));
    gpcg_port_model gpcg_port_model_i (.clk(clk), .rst_n(rst_n), .want(want),
        .port_access(acc));

    always #5 clk = ~clk;

    // xorshift keeps the random sequence repeatable
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    // gating register offsets sit sixteen bytes apart
    function [11:0] off(input integer n);
        off = `GPCG_RUN_PORT_GATE_OFF + {n[7:0], 4'h0};
    endfunction
    // sleep tables only count with auto gating set
    function [7:0] exp_en(input auto_sleep_gating_select, input [1:0] m);
        exp_en = !auto_sleep_gating_select ? v[0][7:0] : (m == 2'h1) ? v[1][7:0] : (m == 2'h2) ? v[2][7:0] : v[0][7:0];
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // bus response codes and port outputs each get their own compare
    task chk_resp(input [1:0] got, input [1:0] exp);
        begin
            chk({30'h00000000, got}, {30'h00000000, exp});
        end
    endtask
    task chk_port(input [7:0] got, input [7:0] exp);
        begin
            chk({24'h000000, got}, {24'h000000, exp});
        end
    endtask
    // write: address and data offered together, each released when taken
    task wr(input [11:0] a, input [31:0] x);
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= x;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (bvalid !== 1'b1);
            r = bresp;
            bready <= 1'b0;
        end
    endtask
    task rd(input [11:0] a);
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge clk);
                if (arready) arvalid <= 1'b0;
            end while (rvalid !== 1'b1);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
        end
    endtask
    task test_done;
        begin
            $display("checks %0d miscompares %0d", checks_done, miscompares);
            if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask

    // a hang is cut short well past the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            test_done;
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 3; i = i + 1) begin
            rd(off(i));
            chk(d, 32'h00000000);
        end
        // all ones first, so the upper bits must be dropped
        for (k = 0; k < 3; k = k + 1) begin
            for (i = 0; i < 3; i = i + 1) begin
                rnd = xs(rnd);
                v[i] = (k == 0) ? 32'hffffffff : rnd;
                wr(off(i), v[i]);
                chk_resp(r, `GPCG_RESP_OKAY);
                rd(off(i));
                chk(d, {24'h000000, v[i][7:0]});
            end
        end
        // every auto gating setting against every power mode
        for (k = 0; k < 8; k = k + 1) begin
            wr(`GPCG_RUN_CLOCK_CONFIG_OFF, {4'h0, k[2], 27'h0000000});
            wr(`GPCG_POWER_MODE_OFF, {30'h00000000, k[1:0]});
            chk_port(en, exp_en(k[2], k[1:0]));
            // both settings read back, the mode register with the live enables
            rd(`GPCG_RUN_CLOCK_CONFIG_OFF);
            chk(d, {4'h0, k[2], 27'h0000000});
            rd(`GPCG_POWER_MODE_OFF);
            chk(d, {16'h0000, exp_en(k[2], k[1:0]), 6'h00, k[1:0]});
        end
        // enable first, then touch ports; the first round hits every gated port
        for (k = 0; k < 6; k = k + 1) begin
            rnd = xs(rnd);
            v[0] = (k == 0) ? 32'h00000000 : rnd;
            wr(`GPCG_RUN_PORT_GATE_OFF, v[0]);
            want <= (k == 0) ? 8'hff : rnd[15:8];
            repeat (2) @(posedge clk);
            chk_port(flt, want & ~v[0][7:0]);
            chk_port(en, v[0][7:0]);
        end
        // reset again with enables set: every table must come back clear
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk_port(en, 8'h00);
        for (i = 0; i < 3; i = i + 1) begin
            rd(off(i));
            chk(d, 32'h00000000);
        end
        wr(12'h200, 32'hffffffff);
        chk_resp(r, `GPCG_RESP_SLVERR);
        rd(12'h204);
        chk_resp(r, `GPCG_RESP_SLVERR);
        test_done;
    end
endmodule

bind gpcg_top gpcg_properties #(.N_PORTS(N_PORTS)) gpcg_properties_i (.clk(clk),
    .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port_access(port_access), .port_clk_en(port_clk_en),
    .port_fault(port_fault));
